//--- cmpc_map.svh
`ifndef CMPC_MAP_SVH
`define CMPC_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CMPC_OFS_CTRL     12'h000
`define CMPC_OFS_STATUS   12'h004
`define CMPC_OFS_MASK     12'h008
`define CMPC_OFS_PORT     12'h00C

// ****************************************
// Control register fields
// ****************************************
`define CMPC_BIT_SEL      7
`define CMPC_BIT_ON       6
`define CMPC_BIT_INV      5
`define CMPC_BIT_RES      4
`define CMPC_BIT_ROUTE    3
`define CMPC_BIT_EDGE_HI  2
`define CMPC_BIT_EDGE_LO  1
`define CMPC_BIT_HYS      0
`define CMPC_CTRL_RESET   8'h81
`define CMPC_CTRL_WMASK   8'hEF

// ****************************************
// Status and mask fields
// ****************************************
`define CMPC_BIT_CHG      0
`define CMPC_STAT_WIDTH   1
`define CMPC_MASK_RESET   1'h0

// ****************************************
// Port readback register fields
// ****************************************
`define CMPC_PORT_DATA_LO 0
`define CMPC_PORT_CTL_LO  2
`define CMPC_PORT_HI      3
`define CMPC_PULL_HI      5
`define CMPC_PULL_LO      4
`define CMPC_PULL_RESET   2'h0
`define CMPC_PORT_RESET   4'h0

`endif

//--- cmpc_pkg.sv
package cmpc_pkg;

  typedef enum logic [1:0] {
    CMPC_EDGE_RISE = 2'h0,
    CMPC_EDGE_FALL = 2'h1,
    CMPC_EDGE_BOTH = 2'h2,
    CMPC_EDGE_ANY  = 2'h3
  } cmpc_edge_t;

  typedef struct packed {
    logic       inputPinSelect;
    logic       comparatorOn;
    logic       outputInvert;
    logic       routeInternal;
    cmpc_edge_t irqEdgeSelect;
    logic       hysteresisOn;
  } cmpc_ctrl_t;

  typedef struct packed {
    logic [1:0] portControl;
    logic [1:0] portData;
  } cmpc_port_t;

endpackage

//--- cmpc_sync.sv
`timescale 1ns/100ps

module cmpc_sync (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic async,
  output logic      level,
  output logic      changed
);

  logic [2:0] stage;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], async};
    end
  end

  // Level moves only when stages two and three agree
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      level   <= 1'b0;
      changed <= 1'b0;
    end else begin
      changed <= 1'b0;
      if (stage[1] == stage[2] && stage[2] != level) begin
        level   <= stage[2];
        changed <= 1'b1;
      end
    end
  end

endmodule

//--- cmpc_top.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "cmpc_map.svh"

module cmpc_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        analogDecision,
  input  wire logic        sleepMode,
  output logic             comparatorPower,
  output logic             hysteresisEnable,
  output logic             analogInputConnect,
  output logic      [1:0]  pullHighEnable,
  output logic             compareOutPin,
  output logic             compareOutPinEnable,
  output logic             irq,
  output logic             wakeUp
);

  // ****************************************
  // Register state
  // ****************************************
  cmpc_pkg::cmpc_ctrl_t ctrl;
  cmpc_pkg::cmpc_port_t port;
  logic [1:0]           pullCfg;
  logic                 status;
  logic                 mask;
  logic                 compareResult;
  logic                 rawLevel;
  logic                 setupCycle;
  logic                 wrCtrl;
  logic                 wrStatus;
  logic                 wrMask;
  logic                 wrPort;
  logic                 prevResult;
  logic                 resultValid;
  logic                 next_result;
  logic                 edgeHit;
  logic                 wrEn;
  logic                 rdEn;
  logic                 addrOk;
  logic                 clearChg;
  logic [31:0]          next_prdata;
  logic [1:0]           pinRead;
  logic [1:0]           next_pull;

  localparam logic [7:0] CTRL_RESET = `CMPC_CTRL_RESET;

  // ****************************************
  // Bus decode
  // ****************************************
  assign setupCycle = psel && !penable;
  assign wrEn       = psel && penable && pwrite;
  assign rdEn       = setupCycle && !pwrite;
  assign wrCtrl     = wrEn && paddr == `CMPC_OFS_CTRL;
  assign wrStatus   = wrEn && paddr == `CMPC_OFS_STATUS;
  assign wrMask     = wrEn && paddr == `CMPC_OFS_MASK;
  assign wrPort     = wrEn && paddr == `CMPC_OFS_PORT;
  assign addrOk = paddr == `CMPC_OFS_CTRL || paddr == `CMPC_OFS_STATUS ||
                  paddr == `CMPC_OFS_MASK || paddr == `CMPC_OFS_PORT;

  // ****************************************
  // Synchroniser
  // ****************************************
  cmpc_sync u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .async   (analogDecision),
    .level   (rawLevel),
    .changed ()
  );

  // ****************************************
  // Control, port and mask registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl.inputPinSelect <= CTRL_RESET[`CMPC_BIT_SEL];
      ctrl.comparatorOn   <= CTRL_RESET[`CMPC_BIT_ON];
      ctrl.outputInvert   <= CTRL_RESET[`CMPC_BIT_INV];
      ctrl.routeInternal  <= CTRL_RESET[`CMPC_BIT_ROUTE];
      ctrl.irqEdgeSelect  <= cmpc_pkg::cmpc_edge_t'(
                             CTRL_RESET[`CMPC_BIT_EDGE_HI:`CMPC_BIT_EDGE_LO]);
      ctrl.hysteresisOn   <= CTRL_RESET[`CMPC_BIT_HYS];
    end else if (wrCtrl) begin
      ctrl.inputPinSelect <= pwdata[`CMPC_BIT_SEL];
      ctrl.comparatorOn   <= pwdata[`CMPC_BIT_ON];
      ctrl.outputInvert   <= pwdata[`CMPC_BIT_INV];
      ctrl.routeInternal  <= pwdata[`CMPC_BIT_ROUTE];
      ctrl.irqEdgeSelect  <= cmpc_pkg::cmpc_edge_t'(
                             pwdata[`CMPC_BIT_EDGE_HI:`CMPC_BIT_EDGE_LO]);
      ctrl.hysteresisOn   <= pwdata[`CMPC_BIT_HYS];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      port <= cmpc_pkg::cmpc_port_t'(`CMPC_PORT_RESET);
    end else if (wrPort) begin
      port <= cmpc_pkg::cmpc_port_t'(
                pwdata[`CMPC_PORT_HI:`CMPC_PORT_DATA_LO]);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pullCfg <= `CMPC_PULL_RESET;
    end else if (wrPort) begin
      pullCfg <= pwdata[`CMPC_PULL_HI:`CMPC_PULL_LO];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask <= `CMPC_MASK_RESET;
    end else if (wrMask) begin
      mask <= pwdata[`CMPC_BIT_CHG];
    end
  end

  // ****************************************
  // Stored result
  // ****************************************
  // Inversion applied after sync; comparator off holds result low
  assign next_result = ctrl.comparatorOn &
                       (rawLevel ^ ctrl.outputInvert);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      compareResult <= 1'b0;
    end else begin
      compareResult <= next_result;
    end
  end

  // Previous result feeds the edge detector
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prevResult <= 1'b0;
    end else begin
      prevResult <= compareResult;
    end
  end

  // Holds off edge detection until the result pipe has loaded
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      resultValid <= 1'b0;
    end else begin
      resultValid <= 1'b1;
    end
  end

  // ****************************************
  // Edge detect and interrupt
  // ****************************************
  always_comb begin
    edgeHit = 1'b0;
    if (resultValid && ctrl.comparatorOn) begin
      unique case (ctrl.irqEdgeSelect)
        cmpc_pkg::CMPC_EDGE_RISE: edgeHit = compareResult && !prevResult;
        cmpc_pkg::CMPC_EDGE_FALL: edgeHit = !compareResult && prevResult;
        cmpc_pkg::CMPC_EDGE_BOTH,
        cmpc_pkg::CMPC_EDGE_ANY:  edgeHit = compareResult != prevResult;
      endcase
    end
  end

  assign clearChg = wrStatus && pwdata[`CMPC_BIT_CHG];

  // Set wins over a same-cycle clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status <= 1'b0;
    end else if (edgeHit) begin
      status <= 1'b1;
    end else if (clearChg) begin
      status <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt and wake outputs
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (status | edgeHit) & mask;
    end
  end

  // Only a fresh edge wakes; a preset flag blocks it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wakeUp <= 1'b0;
    end else begin
      wakeUp <= sleepMode & edgeHit & !status;
    end
  end

  // ****************************************
  // Analog and pin controls
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      comparatorPower <= 1'b0;
    end else begin
      comparatorPower <= ctrl.comparatorOn;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hysteresisEnable <= 1'b0;
    end else begin
      hysteresisEnable <= ctrl.hysteresisOn;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      analogInputConnect <= 1'b0;
    end else begin
      analogInputConnect <= ctrl.inputPinSelect;
    end
  end

  // Pull-highs cut on both pins while the comparator owns the pins
  generate
    for (genvar i = 0; i < 2; i++) begin : g_pull
      assign next_pull[i] = ctrl.inputPinSelect ? 1'b0 : pullCfg[i];
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pullHighEnable <= 2'h0;
    end else begin
      pullHighEnable <= next_pull;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      compareOutPin <= 1'b0;
    end else begin
      compareOutPin <= compareResult;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      compareOutPinEnable <= 1'b0;
    end else begin
      compareOutPinEnable <= !ctrl.routeInternal;
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  // Control bit set reads zero while the input pin is selected; otherwise reads port data
  generate
    for (genvar i = 0; i < 2; i++) begin : g_pin
      assign pinRead[i] = ctrl.inputPinSelect &&
                          port.portControl[i] ? 1'b0 : port.portData[i];
    end
  endgenerate

  always_comb begin
    next_prdata = 32'h0;
    unique case (paddr)
      `CMPC_OFS_CTRL: begin
        next_prdata[`CMPC_BIT_SEL]   = ctrl.inputPinSelect;
        next_prdata[`CMPC_BIT_ON]    = ctrl.comparatorOn;
        next_prdata[`CMPC_BIT_INV]   = ctrl.outputInvert;
        next_prdata[`CMPC_BIT_RES]   = compareResult;
        next_prdata[`CMPC_BIT_ROUTE] = ctrl.routeInternal;
        next_prdata[`CMPC_BIT_EDGE_HI:`CMPC_BIT_EDGE_LO] =
          ctrl.irqEdgeSelect;
        next_prdata[`CMPC_BIT_HYS]   = ctrl.hysteresisOn;
      end
      `CMPC_OFS_STATUS: next_prdata[`CMPC_BIT_CHG] = status;
      `CMPC_OFS_MASK:   next_prdata[`CMPC_BIT_CHG] = mask;
      `CMPC_OFS_PORT:   next_prdata[5:0] = {pullCfg, port.portControl,
                                            pinRead};
      default:          next_prdata = 32'h0;
    endcase
  end

  // ****************************************
  // APB response
  // ****************************************
  // Answer one cycle after setup: pready high in the access cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= setupCycle;
    end
  end

  // Unmapped addresses answer with an error and have no effect
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setupCycle && !addrOk;
    end
  end

  // Read data taken at setup, standing through the access cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (rdEn) begin
      prdata <= next_prdata;
    end
  end

endmodule

//--- cmpc_analog.sv
`timescale 1ns/100ps

module cmpc_analog (
  input  wire logic powered,
  input  int        plusMv,
  input  int        minusMv,
  output logic      decision
);
  // Unpowered comparator holds its decision low
  always_comb decision = powered && (plusMv > minusMv);
endmodule

//--- cmpc_chk.sv
`timescale 1ns/100ps

module cmpc_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sleepMode,
  input wire logic        comparatorPower,
  input wire logic        analogInputConnect,
  input wire logic [1:0]  pullHighEnable,
  input wire logic        compareOutPin,
  input wire logic        wakeUp
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && $past(psel);
  endsequence
  a_ready_answer: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_place: assert property (pready |-> s_access)
    else $error("pready outside access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_decode: assert property (pready |->
    pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}))
    else $error("pslverr wrong for address");
  a_pull_cut: assert property (
    analogInputConnect |-> pullHighEnable == 2'h0)
    else $error("pull-high left on selected pins");
  a_power_quiet: assert property (
    !comparatorPower [*4] |-> !compareOutPin)
    else $error("output moves while powered down");
  a_wake_sleep: assert property (wakeUp |-> $past(sleepMode))
    else $error("wake outside sleep");
  a_wake_pulse: assert property (wakeUp |=> !wakeUp)
    else $error("wake longer than one cycle");
endmodule

bind cmpc_top cmpc_chk chk (.*);

//--- testbench.sv
`timescale 1ns/100ps
`include "cmpc_map.svh"

module testbench;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        analogDecision, sleepMode, comparatorPower, hysteresisEnable;
  logic        analogInputConnect, compareOutPin, compareOutPinEnable;
  logic        irq, wakeUp, err;
  logic [1:0]  pullHighEnable;
  int          plusMv, minusMv, num_errors, comparisons, w0;
  int          wakes = 0;

  cmpc_top uut (.*);
  cmpc_analog far (
    .powered  (comparatorPower),
    .plusMv   (plusMv),
    .minusMv  (minusMv),
    .decision (analogDecision)
  );

  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) if (wakeUp === 1'b1) wakes <= wakes + 1;

  task check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task set_in(input int p, m);
    @(posedge clk_sys);
    plusMv <= p;
    minusMv <= m;
    repeat (10) @(posedge clk_sys);
  endtask

  task t_reset;
    apb(0, `CMPC_OFS_CTRL, 0);
    check("ctrl", rdat, 32'h81);
    check("hys", hysteresisEnable, 1);
    check("sel", analogInputConnect, 1);
    apb(0, 12'h010, 0);
    check("slverr", err, 1);
    check("bad rd", rdat, 0);
  endtask

  task t_pins;
    apb(1, `CMPC_OFS_PORT, 32'h37);
    apb(0, `CMPC_OFS_PORT, 0);
    check("port sel", rdat[1:0], 2'h2);
    check("pull sel", pullHighEnable, 0);
    apb(1, `CMPC_OFS_CTRL, 0);
    repeat (2) @(posedge clk_sys);
    check("pull io", pullHighEnable, 3);
    check("conn io", analogInputConnect, 0);
    check("hys off", hysteresisEnable, 0);
    check("pin oe", compareOutPinEnable, 1);
    apb(0, `CMPC_OFS_PORT, 0);
    check("port io", rdat[1:0], 2'h3);
  endtask

  task t_edges;
    for (int e = 0; e < 4; e++) begin
      set_in(0, 100);
      apb(1, `CMPC_OFS_CTRL, 32'hC0 | (e << 1));
      apb(1, `CMPC_OFS_MASK, 1);
      apb(1, `CMPC_OFS_STATUS, 1);
      set_in(100, 0);
      apb(0, `CMPC_OFS_STATUS, 0);
      check("rise flag", rdat[0], e != 1);
      check("rise irq", irq, e != 1);
      check("pin", compareOutPin, 1);
      apb(0, `CMPC_OFS_CTRL, 0);
      check("result", rdat[4], 1);
      apb(1, `CMPC_OFS_STATUS, 1);
      set_in(0, 100);
      apb(0, `CMPC_OFS_STATUS, 0);
      check("fall flag", rdat[0], e != 0);
    end
  endtask

  task t_invert;
    apb(1, `CMPC_OFS_CTRL, 32'hEC);
    apb(1, `CMPC_OFS_MASK, 0);
    apb(0, `CMPC_OFS_CTRL, 0);
    check("inv result", rdat[4], 1);
    check("pin oe off", compareOutPinEnable, 0);
    check("masked irq", irq, 0);
    apb(1, `CMPC_OFS_CTRL, 32'hAC);
    apb(1, `CMPC_OFS_STATUS, 1);
    set_in(100, 0);
    check("power", comparatorPower, 0);
    apb(0, `CMPC_OFS_STATUS, 0);
    check("off flag", rdat[0], 0);
  endtask

  task t_sleep;
    set_in(0, 100);
    apb(1, `CMPC_OFS_CTRL, 32'hC4);
    apb(1, `CMPC_OFS_STATUS, 1);
    sleepMode <= 1;
    w0 = wakes;
    set_in(100, 0);
    check("wake", wakes - w0, 1);
    set_in(0, 100);
    check("no wake", wakes - w0, 1);
    sleepMode <= 0;
  endtask

  task end_sim;
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, sleepMode} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    plusMv = 0;
    minusMv = 0;
    num_errors = 0;
    comparisons = 0;
    rst = 1;
    repeat (20) @(posedge clk_sys);
    rst <= 0;
    t_reset;
    t_pins;
    t_edges;
    t_invert;
    t_sleep;
    end_sim;
  end

  initial begin
    #5000000;
    num_errors++;
    end_sim;
  end
endmodule
